// ### rtl/pfcps_consts.svh
`ifndef PFCPS_CONSTS_SVH
`define PFCPS_CONSTS_SVH
// Notes on behaviour
// - Digitize coefficient pin before switching, then hold
// - Low captured coefficient disables compensation entirely
// - Any trip stops gate, starts restart delay
// - During delay, bias toggles between supply levels
// - After delay, bias off, full reset at turn-off
// - Feedback above selected level four samples trips
// - Supply above limit for filter time trips
// - Feedback low for continuous switching time trips
// - Current above high level trips immediately
// - Pulse current limit ends each on-time
// - First pulse uses reduced current limit
// - No sense rise during first pulse trips
// - First on-time capped inversely to input voltage
// - Zero-cross event derived each half line cycle
// - Sixty consecutive limited intervals trip overload
// - Thermal shutdown with upper and lower levels
// - Pin pulled first pulse, sampled second, selects set

`define PFCPS_CLK_KHZ 25000
`define PFCPS_RESTART_MS 3000
`define PFCPS_RESTART_CYC (`PFCPS_RESTART_MS * `PFCPS_CLK_KHZ)
`define PFCPS_FBLOW_MS 35
`define PFCPS_FBLOW_CYC (`PFCPS_FBLOW_MS * `PFCPS_CLK_KHZ)
`define PFCPS_VDDOV_US 10
`define PFCPS_VDDOV_CYC (`PFCPS_VDDOV_US * `PFCPS_CLK_KHZ / 1000)
`define PFCPS_SETDLY_US 5
`define PFCPS_SETDLY_CYC (`PFCPS_SETDLY_US * `PFCPS_CLK_KHZ / 1000)
`define PFCPS_FBOV_SAMPLES 4
`define PFCPS_OVERLOAD_INTERVALS 60
`define PFCPS_ADC_FS_MV 5000
`define PFCPS_PFDIS_MV 1500
`define PFCPS_PFDIS_CODE (`PFCPS_PFDIS_MV * 256 / `PFCPS_ADC_FS_MV)
`define PFCPS_FIRST_TON_K 800000

`define PFCPS_ADDR_CTRL 32'h0000_0000
`define PFCPS_ADDR_STATUS 32'h0000_0004
`define PFCPS_ADDR_COEF 32'h0000_0008
`define PFCPS_ADDR_COUNT 32'h0000_000c
`define PFCPS_CTRL_EN_BIT 0
`define PFCPS_CTRL_RESET 1'b1
`endif

// ### rtl/pfcps_pkg.sv
package pfcps_pkg;
  typedef enum logic [3:0] {
    ST_CAPTURE = 4'b0001,
    ST_RUN = 4'b0010,
    ST_RESTART = 4'b0100,
    ST_DRAIN = 4'b1000
  } pfcps_state_t;

  typedef enum logic [2:0] {
    TRIP_NONE = 3'h0,
    TRIP_OUT_OV = 3'h1,
    TRIP_SHORT = 3'h2,
    TRIP_OVERCUR = 3'h3,
    TRIP_SENSE_SHORT = 3'h4,
    TRIP_OVERLOAD = 3'h5,
    TRIP_THERMAL = 3'h6
  } pfcps_trip_t;

  typedef struct packed {
    logic cs_above_limit;
    logic cs_above_high;
    logic cs_above_short;
    logic fb_sample_valid;
    logic fb_above_ov0;
    logic fb_above_ov1;
    logic fb_below_short;
    logic vdd_above_ov;
    logic vdd_below_bias_on;
    logic vdd_above_bias_off;
    logic vdd_below_off;
    logic temp_above_hi;
    logic temp_below_lo;
    logic line_above_cross;
    logic pf_above_ref;
  } pfcps_sense_t;
endpackage : pfcps_pkg

// ### rtl/pfcps_persist.sv
`timescale 1ns/10ps
module pfcps_persist (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Run control
  input wire logic clear,
  input wire logic step,
  input wire logic cond,
  input wire logic [23:0] limit,
  // Result
  output logic [23:0] count,
  output logic hit
);
  logic [23:0] next_count;
  wire at_limit = count >= limit;
  // Saturates so a long run cannot wrap and look like a fresh start
  assign next_count = clear ? 24'h0 :
                      !step ? count :
                      !cond ? 24'h0 :
                      at_limit ? count : 24'(count + 24'h1);
  assign hit = step & cond & ~clear & (count >= 24'(limit - 24'h1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 24'h0;
    end else if (ce) begin
      count <= next_count;
    end
  end
endmodule : pfcps_persist

// ### rtl/pfcps_top.sv
`timescale 1ns/10ps
`include "pfcps_consts.svh"
module pfcps_top import pfcps_pkg::*; #(
  parameter int unsigned RESTART_CYC = `PFCPS_RESTART_CYC,
  parameter int unsigned FBLOW_CYC = `PFCPS_FBLOW_CYC
) (
  // Clock, lockout reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  // Comparator levels
  input wire pfcps_sense_t sense,
  // On-time request and line information
  input wire logic gate_request,
  input wire logic [7:0] vin_peak_code,
  // Coefficient converter
  output logic adc_start,
  input wire logic adc_done,
  input wire logic [7:0] adc_data,
  // Power stage controls
  output logic gate_out,
  output logic current_limit_low,
  output logic pf_pulldown,
  output logic hv_bias_on,
  output logic pf_comp_enable,
  output logic threshold_set_one,
  output logic full_reset
);
  localparam logic [26:0] RESTART_LAST = 27'(RESTART_CYC - 1);
  localparam logic [6:0] SET_LAST = 7'(`PFCPS_SETDLY_CYC - 1);
  localparam logic [7:0] PFDIS_CODE = 8'(`PFCPS_PFDIS_CODE);
  localparam logic [23:0] TON_K = 24'(`PFCPS_FIRST_TON_K);

  // Product test avoids a divider in the first-pulse cap
  function automatic logic ton_reached(input logic [15:0] t,
                                       input logic [7:0] v);
    ton_reached = ({8'h0, t} * {16'h0, v}) >= TON_K;
  endfunction : ton_reached

  pfcps_state_t state;
  pfcps_state_t next_state;
  pfcps_trip_t trip;
  pfcps_trip_t next_trip;
  pfcps_trip_t hit_code;
  logic [7:0] coef_code;
  logic coef_valid;
  logic adc_busy;
  logic [1:0] pulse_num;
  logic req_d;
  logic line_d;
  logic [15:0] ton_cnt;
  logic sense_seen;
  logic limit_seen;
  logic [26:0] restart_cnt;
  logic [6:0] set_cnt;
  logic set_done;
  logic thermal;
  logic ctrl_enable;
  logic [31:0] next_prdata;
  logic [23:0] fbov_cnt;
  logic [23:0] vddov_cnt;
  logic [23:0] fblow_cnt;
  logic [23:0] overload_cnt;
  logic fbov_hit;
  logic vddov_hit;
  logic fblow_hit;
  logic overload_hit;

  wire st_capture = state == ST_CAPTURE;
  wire st_run = state == ST_RUN;
  wire st_restart = state == ST_RESTART;
  wire st_drain = state == ST_DRAIN;
  wire soft_clear = st_drain & sense.vdd_below_off;
  wire pulse_start = gate_request & ~req_d;
  wire cross_event = sense.line_above_cross ^ line_d;
  wire first_pulse = pulse_num == 2'd1;
  wire ton_cap = first_pulse & ton_reached(ton_cnt, vin_peak_code);
  wire on_end = gate_out & (~gate_request | sense.cs_above_limit
                            | ton_cap);
  wire limit_now = gate_out & sense.cs_above_limit;
  wire sense_hit = first_pulse & on_end & ~sense_seen
                   & ~sense.cs_above_short;
  wire fbov_cond = threshold_set_one ? sense.fb_above_ov1
                                     : sense.fb_above_ov0;
  wire switching = st_run & ctrl_enable;
  wire any_hit = st_run & (hit_code != TRIP_NONE);
  wire gate_allowed = switching & ~thermal & ~any_hit;
  wire restart_done = st_restart & (restart_cnt == RESTART_LAST);

  // Fixed priority when several faults land in one cycle
  assign hit_code = sense.cs_above_high ? TRIP_OVERCUR :
                    sense_hit ? TRIP_SENSE_SHORT :
                    (fbov_hit | vddov_hit) ? TRIP_OUT_OV :
                    fblow_hit ? TRIP_SHORT :
                    overload_hit ? TRIP_OVERLOAD :
                    sense.temp_above_hi ? TRIP_THERMAL : TRIP_NONE;

  pfcps_persist u_fbov (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .clear(~st_run), .step(sense.fb_sample_valid), .cond(fbov_cond),
    .limit(24'(`PFCPS_FBOV_SAMPLES)), .count(fbov_cnt), .hit(fbov_hit)
  );
  pfcps_persist u_vddov (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .clear(~st_run), .step(1'b1), .cond(sense.vdd_above_ov),
    .limit(24'(`PFCPS_VDDOV_CYC)), .count(vddov_cnt), .hit(vddov_hit)
  );
  pfcps_persist u_fblow (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .clear(~st_run), .step(switching), .cond(sense.fb_below_short),
    .limit(24'(FBLOW_CYC)), .count(fblow_cnt), .hit(fblow_hit)
  );
  pfcps_persist u_overload (
    .pclk(pclk), .presetn(presetn), .ce(ce),
    .clear(~st_run), .step(cross_event), .cond(limit_seen | limit_now),
    .limit(24'(`PFCPS_OVERLOAD_INTERVALS)), .count(overload_cnt),
    .hit(overload_hit)
  );

  always_comb begin
    next_state = state;
    case (state)
      ST_CAPTURE: begin
        if (coef_valid) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (any_hit) begin
          next_state = ST_RESTART;
        end
      end
      ST_RESTART: begin
        if (restart_done) begin
          next_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (soft_clear) begin
          next_state = ST_CAPTURE;
        end
      end
      default: next_state = ST_CAPTURE;
    endcase
  end

  // Only the first fault is kept; later ones wait for the full reset
  assign next_trip = soft_clear ? TRIP_NONE :
                     (any_hit && trip == TRIP_NONE) ? hit_code :
                     trip;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_CAPTURE;
      trip <= TRIP_NONE;
      full_reset <= 1'b0;
    end else if (ce) begin
      state <= next_state;
      trip <= next_trip;
      full_reset <= soft_clear;
    end
  end

  // Conversion runs while the gate is held off, so no switching noise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_start <= 1'b0;
      adc_busy <= 1'b0;
      coef_valid <= 1'b0;
      coef_code <= 8'h00;
    end else if (ce) begin
      // Busy is set one edge late, so the pulse masks itself
      adc_start <= st_capture & ~adc_busy & ~adc_start & ~coef_valid;
      if (soft_clear) begin
        adc_busy <= 1'b0;
        coef_valid <= 1'b0;
        coef_code <= 8'h00;
      end else if (adc_busy & adc_done) begin
        adc_busy <= 1'b0;
        coef_valid <= 1'b1;
        coef_code <= adc_data;
      end else if (adc_start) begin
        adc_busy <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pf_comp_enable <= 1'b0;
    end else if (ce) begin
      pf_comp_enable <= ~soft_clear & coef_valid
                        & (coef_code >= PFDIS_CODE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_d <= 1'b0;
      line_d <= 1'b0;
      gate_out <= 1'b0;
      ton_cnt <= 16'h0000;
    end else if (ce) begin
      req_d <= gate_request;
      line_d <= sense.line_above_cross;
      gate_out <= gate_allowed & (gate_out ? ~on_end : pulse_start);
      ton_cnt <= !gate_out ? 16'h0000 :
                 (&ton_cnt) ? ton_cnt : 16'(ton_cnt + 16'h1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_num <= 2'd0;
      sense_seen <= 1'b0;
    end else if (ce) begin
      if (soft_clear) begin
        pulse_num <= 2'd0;
      end else if (gate_allowed & pulse_start & ~&pulse_num) begin
        pulse_num <= 2'(pulse_num + 2'd1);
      end
      sense_seen <= ~soft_clear & (sense_seen | (gate_out & first_pulse
                                   & sense.cs_above_short));
    end
  end

  // Low limit also stands before the first pulse so it is set in time
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      current_limit_low <= 1'b1;
      pf_pulldown <= 1'b0;
    end else if (ce) begin
      current_limit_low <= ~pulse_num[1];
      pf_pulldown <= ~st_capture & ~pulse_num[1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      set_cnt <= 7'h00;
      set_done <= 1'b0;
      threshold_set_one <= 1'b0;
    end else if (ce) begin
      if (soft_clear) begin
        set_cnt <= 7'h00;
        set_done <= 1'b0;
        threshold_set_one <= 1'b0;
      end else if (pulse_num[1] & ~set_done) begin
        set_cnt <= 7'(set_cnt + 7'h01);
        if (set_cnt == SET_LAST) begin
          set_done <= 1'b1;
          threshold_set_one <= ~sense.pf_above_ref;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_seen <= 1'b0;
      thermal <= 1'b0;
    end else if (ce) begin
      limit_seen <= ~cross_event & (limit_seen | limit_now);
      thermal <= sense.temp_above_hi
                 | (thermal & ~sense.temp_below_lo);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      restart_cnt <= 27'h0;
      hv_bias_on <= 1'b0;
    end else if (ce) begin
      restart_cnt <= st_restart ? 27'(restart_cnt + 27'h1) : 27'h0;
      hv_bias_on <= st_restart & ~restart_done
                    & (sense.vdd_below_bias_on
                       | (hv_bias_on & ~sense.vdd_above_bias_off));
    end
  end

  // APB: zero wait states, read data latched in the setup cycle
  wire apb_setup = psel & ~penable;
  wire hit_ctrl = paddr == `PFCPS_ADDR_CTRL;
  wire hit_status = paddr == `PFCPS_ADDR_STATUS;
  wire hit_coef = paddr == `PFCPS_ADDR_COEF;
  wire hit_count = paddr == `PFCPS_ADDR_COUNT;
  wire mapped = hit_ctrl | hit_status | hit_coef | hit_count;
  wire ctrl_write = psel & penable & pwrite & hit_ctrl;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit_ctrl) begin
      next_prdata = {31'h0, ctrl_enable};
    end else if (hit_status) begin
      next_prdata = {18'h0, pulse_num, hv_bias_on, pf_comp_enable,
                     set_done, threshold_set_one, thermal, trip, state};
    end else if (hit_coef) begin
      next_prdata = {23'h0, coef_valid, coef_code};
    end else if (hit_count) begin
      next_prdata = {26'h0, overload_cnt[5:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      ctrl_enable <= `PFCPS_CTRL_RESET;
    end else if (ce) begin
      if (apb_setup & ~pwrite) begin
        prdata <= next_prdata;
      end
      if (ctrl_write) begin
        ctrl_enable <= pwdata[`PFCPS_CTRL_EN_BIT];
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence run_trip_s;
    ce && st_run && any_hit;
  endsequence
  sequence restart_entry_s;
    st_restart && !gate_out && restart_cnt == 27'h0;
  endsequence
  // Fourth qualifying sample; samples are pulses, never back to back
  sequence fbov_run_s;
    ce && st_run && trip == TRIP_NONE && sense.fb_sample_valid
    && fbov_cond && fbov_cnt == 24'(`PFCPS_FBOV_SAMPLES - 1);
  endsequence

  coef_hold_a: assert property (
    coef_valid && $past(coef_valid) |-> $stable(coef_code))
    else $error("coefficient changed while held");
  quiet_capture_a: assert property (
    st_capture |-> !gate_out) else $error("gate active during capture");
  pf_disable_a: assert property (
    pf_comp_enable |-> coef_valid && coef_code >= PFDIS_CODE)
    else $error("compensation on below disable level");
  trip_stop_a: assert property (
    run_trip_s |=> restart_entry_s) else $error("trip did not stop gate");
  bias_low_a: assert property (
    ce && st_restart && !restart_done && sense.vdd_below_bias_on
    |=> hv_bias_on) else $error("bias not on at low supply");
  restart_end_a: assert property (
    ce && restart_done |=> st_drain && !hv_bias_on)
    else $error("restart delay end mishandled");
  fb_over_a: assert property (
    fbov_run_s |=> trip != TRIP_NONE) else $error("feedback over missed");
  vdd_filter_a: assert property (
    ce && !sense.vdd_above_ov |=> vddov_cnt == 24'h0)
    else $error("supply filter not restarted");
  short_timer_a: assert property (
    ce && switching && !sense.fb_below_short |=> fblow_cnt == 24'h0)
    else $error("short timer not restarted");
  high_current_a: assert property (
    ce && st_run && sense.cs_above_high |=> !gate_out && st_restart)
    else $error("high current did not trip at once");
  pulse_limit_a: assert property (
    ce && gate_out && sense.cs_above_limit |=> !gate_out)
    else $error("on-time not ended at limit");
  first_limit_a: assert property (
    gate_out && first_pulse |-> current_limit_low)
    else $error("first pulse without reduced limit");
  sense_short_a: assert property (
    ce && sense_hit && st_run && trip == TRIP_NONE
    && !sense.cs_above_high |=> trip == TRIP_SENSE_SHORT)
    else $error("sense short not latched");
  thermal_hold_a: assert property (
    ce && thermal && !sense.temp_below_lo |=> thermal)
    else $error("thermal released early");
  pin_release_a: assert property (
    pulse_num[1] && $past(pulse_num[1]) |-> !pf_pulldown)
    else $error("pin still pulled after first pulse");
  trip_latch_a: assert property (
    $past(trip) != TRIP_NONE && !$past(soft_clear) && $past(ce)
    |-> trip == $past(trip)) else $error("latched trip changed");
endmodule : pfcps_top

// ### tb/pfcps_stage_model.sv
`timescale 1ns/10ps
module pfcps_stage_model (
  // Clock
  input wire logic pclk,
  // Controller outputs
  input wire logic adc_start,
  input wire logic gate_out,
  input wire logic hv_bias_on,
  input wire logic pf_pulldown,
  // Scenario knobs
  input wire logic [7:0] coef,
  input wire logic cap_fitted,
  input wire logic rsense_short,
  // Answers
  output logic adc_done = 1'b0,
  output logic [7:0] adc_data = 8'h00,
  output logic cs_short,
  output logic vdd_lo,
  output logic vdd_hi,
  output logic vdd_off,
  output logic pf_ref
);
  int conv = 0;
  int vdd = 180;
  int on_cyc = 0;
  int pf_cyc = 0;
  always @(posedge pclk) begin
    adc_done <= 1'b0;
    // Data lines toggle outside the answer so stale values never match
    adc_data <= ~adc_data;
    if (adc_start) begin
      conv <= 6;
    end else if (conv > 0) begin
      conv <= conv - 1;
      if (conv == 1) begin
        adc_done <= 1'b1;
        adc_data <= coef;
      end
    end
    on_cyc <= gate_out ? on_cyc + 1 : 0;
    // Supply in tenths of a volt; aux winding floor keeps it at 6.0 V
    if (hv_bias_on) begin
      vdd <= vdd + 1;
    end else if (vdd > 60) begin
      vdd <= vdd - 1;
    end
    pf_cyc <= pf_pulldown ? 0 : pf_cyc + 1;
  end
  assign cs_short = !rsense_short && on_cyc > 1;
  assign vdd_lo = vdd < 170;
  assign vdd_hi = vdd > 190;
  assign vdd_off = vdd < 78;
  // A fitted capacitor slows the pin well past the sampling point
  assign pf_ref = !pf_pulldown && (cap_fitted ? pf_cyc > 300 : pf_cyc > 10);
endmodule : pfcps_stage_model

// ### tb/pfc_protection_supervisor_test.sv
`timescale 1ns/10ps
`include "pfcps_consts.svh"
`define CHK(a, e) begin @(negedge pclk); tests_run++; \
  if ((a) !== (e)) begin miscompares++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, e); end \
  @(posedge pclk); end
module pfc_protection_supervisor_test import pfcps_pkg::*;;
  localparam int RCYC = 400;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, err, gate_request = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, r;
  pfcps_sense_t s = '0, sense;
  logic [7:0] vin = 8'h00, coef = 8'h4c, adc_data;
  logic cap_fitted = 1'b1, rshort = 1'b0, adc_start, adc_done, gate_out;
  logic cur_low, pf_pd, bias, pb, pf_en, set_one, full_reset;
  logic m_cs, m_lo, m_hi, m_off, m_ref;
  int miscompares = 0, tests_run = 0, cyc_cnt = 0, n = 0;

  always_comb begin
    sense = s;
    sense.cs_above_short = m_cs;
    sense.vdd_below_bias_on = m_lo;
    sense.vdd_above_bias_off = m_hi;
    sense.vdd_below_off = m_off;
    sense.pf_above_ref = m_ref;
  end

  pfcps_top #(.RESTART_CYC(RCYC), .FBLOW_CYC(50)) u_dut (.pclk(pclk),
    .presetn(presetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .sense(sense),
    .gate_request(gate_request), .vin_peak_code(vin),
    .adc_start(adc_start), .adc_done(adc_done), .adc_data(adc_data),
    .gate_out(gate_out), .current_limit_low(cur_low),
    .pf_pulldown(pf_pd), .hv_bias_on(bias), .pf_comp_enable(pf_en),
    .threshold_set_one(set_one), .full_reset(full_reset));

  pfcps_stage_model u_stage (.pclk(pclk), .adc_start(adc_start),
    .gate_out(gate_out), .hv_bias_on(bias), .pf_pulldown(pf_pd),
    .coef(coef), .cap_fitted(cap_fitted), .rsense_short(rshort),
    .adc_done(adc_done), .adc_data(adc_data), .cs_short(m_cs),
    .vdd_lo(m_lo), .vdd_hi(m_hi), .vdd_off(m_off), .pf_ref(m_ref));

  initial begin
    forever #20 pclk = ~pclk;
  end

  task print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict

  // Hang guard well above the longest planned sequence
  always @(posedge pclk) begin
    cyc_cnt++;
    if (cyc_cnt == 30000) begin
      miscompares++;
      print_verdict();
    end
  end

  task cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc

  task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rst();
    s <= '0;
    gate_request <= 1'b0;
    presetn <= 1'b0;
    cyc(20);
    presetn <= 1'b1;
    apb(1'b0, `PFCPS_ADDR_COEF, 32'h0);
    `CHK(r, 32'h0)
    cyc(14);
  endtask : rst

  task fbs(input logic a, input logic b);
    s.fb_above_ov0 <= a;
    s.fb_above_ov1 <= b;
    s.fb_sample_valid <= 1'b1;
    cyc(1);
    s.fb_sample_valid <= 1'b0;
    cyc(1);
  endtask : fbs

  task ovl(input logic lim);
    gate_request <= 1'b1;
    cyc(4);
    s.cs_above_limit <= lim;
    cyc(1);
    s.cs_above_limit <= 1'b0;
    gate_request <= 1'b0;
    cyc(2);
    s.line_above_cross <= ~s.line_above_cross;
    cyc(2);
  endtask : ovl

  initial begin
    rst();
    apb(1'b0, `PFCPS_ADDR_COEF, 32'h0);
    `CHK(r, 32'h0000_014c)
    `CHK(pf_en, 1'b1)
    apb(1'b0, 32'h0000_0010, 32'h0);
    `CHK({err, r}, 33'h1_0000_0000)
    apb(1'b1, `PFCPS_ADDR_CTRL, 32'h0);
    gate_request <= 1'b1;
    cyc(3);
    `CHK(gate_out, 1'b0)
    gate_request <= 1'b0;
    apb(1'b0, `PFCPS_ADDR_CTRL, 32'h0);
    `CHK(r, 32'h0)
    apb(1'b1, `PFCPS_ADDR_CTRL, 32'h1);
    cyc(1);
    apb(1'b0, `PFCPS_ADDR_CTRL, 32'h0);
    `CHK(r, 32'h1)
    `CHK(cur_low, 1'b1)
    gate_request <= 1'b1;
    cyc(2);
    `CHK(gate_out, 1'b1)
    s.cs_above_limit <= 1'b1;
    cyc(1);
    `CHK(gate_out, 1'b0)
    `CHK(pf_pd, 1'b1)
    s.cs_above_limit <= 1'b0;
    gate_request <= 1'b0;
    cyc(3);
    gate_request <= 1'b1;
    cyc(3);
    gate_request <= 1'b0;
    cyc(3);
    `CHK(cur_low, 1'b0)
    `CHK(pf_pd, 1'b0)
    cyc(150);
    `CHK(set_one, 1'b1)
    repeat (3) fbs(1'b1, 1'b1);
    fbs(1'b1, 1'b0);
    repeat (3) fbs(1'b1, 1'b1);
    apb(1'b0, `PFCPS_ADDR_STATUS, 32'h0);
    `CHK(r[6:4], 3'h0)
    fbs(1'b1, 1'b1);
    s <= '0;
    apb(1'b0, `PFCPS_ADDR_STATUS, 32'h0);
    `CHK(r[6:4], 3'h1)
    // Later faults and requests during the delay must change nothing
    gate_request <= 1'b1;
    s.cs_above_high <= 1'b1;
    pb = bias;
    n = 0;
    repeat (RCYC - 30) begin
      cyc(1);
      if (bias && !pb) n++;
      pb = bias;
    end
    `CHK(gate_out, 1'b0)
    apb(1'b0, `PFCPS_ADDR_STATUS, 32'h0);
    `CHK(r[6:0], 7'h14)
    `CHK(n >= 2, 1'b1)
    cyc(40);
    apb(1'b0, `PFCPS_ADDR_STATUS, 32'h0);
    `CHK(r[3:0], 4'h8)
    `CHK(bias, 1'b0)
    n = 0;
    while (full_reset !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    `CHK(n < 400, 1'b1)
    rst();
    gate_request <= 1'b1;
    cyc(3);
    s.cs_above_high <= 1'b1;
    cyc(1);
    `CHK(gate_out, 1'b0)
    apb(1'b0, `PFCPS_ADDR_STATUS, 32'h0);
    `CHK(r[6:4], 3'h3)
    rshort <= 1'b1;
    rst();
    gate_request <= 1'b1;
    cyc(6);
    gate_request <= 1'b0;
    cyc(3);
    apb(1'b0, `PFCPS_ADDR_STATUS, 32'h0);
    `CHK(r[6:4], 3'h4)
    rshort <= 1'b0;
    rst();
    vin <= 8'hff;
    gate_request <= 1'b1;
    cyc(3100);
    `CHK(gate_out, 1'b1)
    cyc(60);
    `CHK(gate_out, 1'b0)
    gate_request <= 1'b0;
    vin <= 8'h00;
    s.vdd_above_ov <= 1'b1;
    cyc(240);
    apb(1'b0, `PFCPS_ADDR_STATUS, 32'h0);
    `CHK(r[6:4], 3'h0)
    cyc(20);
    apb(1'b0, `PFCPS_ADDR_STATUS, 32'h0);
    `CHK(r[6:4], 3'h1)
    rst();
    s.fb_below_short <= 1'b1;
    for (int i = 0; i < 13; i++) begin
      gate_request <= 1'b1;
      fbs(1'b0, 1'b0);
      cyc(3);
      gate_request <= 1'b0;
      cyc(5);
      if (i == 2) begin
        apb(1'b0, `PFCPS_ADDR_STATUS, 32'h0);
        `CHK(r[6:4], 3'h0)
      end
    end
    apb(1'b0, `PFCPS_ADDR_STATUS, 32'h0);
    `CHK(r[6:4], 3'h2)
    rst();
    repeat (59) ovl(1'b1);
    apb(1'b0, `PFCPS_ADDR_COUNT, 32'h0);
    `CHK(r[5:0], 6'd59)
    ovl(1'b0);
    apb(1'b0, `PFCPS_ADDR_COUNT, 32'h0);
    `CHK(r[5:0], 6'd0)
    repeat (60) ovl(1'b1);
    apb(1'b0, `PFCPS_ADDR_STATUS, 32'h0);
    `CHK(r[6:4], 3'h5)
    rst();
    s.temp_above_hi <= 1'b1;
    cyc(2);
    s.temp_above_hi <= 1'b0;
    apb(1'b0, `PFCPS_ADDR_STATUS, 32'h0);
    `CHK(r[7:4], 4'he)
    s.temp_below_lo <= 1'b1;
    cyc(2);
    apb(1'b0, `PFCPS_ADDR_STATUS, 32'h0);
    `CHK(r[7], 1'b0)
    coef <= 8'h4b;
    cap_fitted <= 1'b0;
    rst();
    `CHK(pf_en, 1'b0)
    // Bare pin rises fast, so the second pulse picks set zero
    repeat (2) begin
      gate_request <= 1'b1;
      cyc(4);
      gate_request <= 1'b0;
      cyc(3);
    end
    cyc(150);
    apb(1'b0, `PFCPS_ADDR_STATUS, 32'h0);
    `CHK(r[9:8], 2'b10)
    repeat (4) fbs(1'b1, 1'b0);
    apb(1'b0, `PFCPS_ADDR_STATUS, 32'h0);
    `CHK(r[6:4], 3'h1)
    print_verdict();
  end
endmodule : pfc_protection_supervisor_test
